// ---- sadc_map.svh ----
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
// Printed offsets step by one, not four: they are indices, byte address = 4 * index
`define SADC_IDX_CONTROL 16'hFE58
`define SADC_IDX_MODE 16'hFE59
`define SADC_IDX_LOW 16'hFE5A
`define SADC_IDX_HIGH 16'hFE5B
`define SADC_ADDR_W 18
`define SADC_RESET_BYTE 8'h00
`define SADC_CHAN_LAST 4'hD
`define SADC_CTRL_WMASK 8'hF7
`define SADC_MODE_WMASK 8'h43
`define SADC_LOW_WMASK 8'h01
`define SADC_BITS_12 4'hC
`define SADC_BITS_8 4'h8
`define SADC_BASE_12 8'h34
`define SADC_BASE_8 8'h20
`define SADC_FIXED_TERM 16'h0002
`define SADC_THIRDS 2'h3
`endif

// ---- sadc_pkg.sv ----
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SETTLE,
    SADC_STEP
  } sadc_state_type;
  typedef struct packed {
    logic [3:0] channel;
    logic fixed_zero;
    logic run;
    logic done;
    logic irq_enable;
  } sadc_control_type;
endpackage : sadc_pkg

// ---- sadc_sequencer.sv ----
// Functional notes
// - Channel field codes 0 to 13 route inputs 0 to 13 to the comparator.
// - Writing start bit 1 begins conversion with current resolution and time.
// - Hardware clears start bit when conversion completes.
// - Writing start bit 0 mid-conversion aborts it; result undefined.
// - Done flag sets when result is placed in result registers.
// - Interrupt request asserts while done flag and enable are both 1.
// - Conversion clock divided 1/1 to 1/128 by three time bits.
// - Mode bit 6 zero selects 12-bit, one selects 8-bit.
// - 8-bit result goes to high register; low register untouched.
// - 12-bit result: top eight to high, low four to low bits 7..4.
// - Reference ladder enabled only while conversion runs.
// - Time code, low-register bit as MSB, decodes ratios 1/1 to 1/128.
// - Conversion lasts ((base/ratio)+2)/3 cycle times, base 52 or 32.
// - First 12-bit conversion after reset or 8-to-12 switch takes double.
// - Reset during conversion clears start bit and halts converter.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_sequencer (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COMPARATOR_HIGH,
  output logic [3:0] CHANNEL_SELECT,
  output logic [11:0] TRIAL_CODE,
  output logic LADDER_ENABLE,
  output logic SAMPLE_STROBE,
  output logic DONE_IRQ
);
  sadc_pkg::sadc_control_type control;
  logic [7:0] mode;
  logic [7:0] result_low;
  logic [7:0] result_high;
  sadc_pkg::sadc_state_type state;
  logic [11:0] approx;
  logic [3:0] bit_index;
  logic [15:0] step_count;
  logic long_pending;
  logic [15:0] fine_count;

  wire bus_access = PSEL && PENABLE;
  wire [15:0] reg_index = PADDR[17:2];
  wire addr_ok = (PADDR[31:`SADC_ADDR_W] == '0) && (PADDR[1:0] == 2'h0);
  wire hit_control = addr_ok && (reg_index == `SADC_IDX_CONTROL);
  wire hit_mode = addr_ok && (reg_index == `SADC_IDX_MODE);
  wire hit_low = addr_ok && (reg_index == `SADC_IDX_LOW);
  wire hit_high = addr_ok && (reg_index == `SADC_IDX_HIGH);
  wire hit_any = hit_control || hit_mode || hit_low || hit_high;
  wire write_control = bus_access && PWRITE && hit_control;
  wire write_mode = bus_access && PWRITE && hit_mode;
  wire write_low = bus_access && PWRITE && hit_low;
  wire write_high = bus_access && PWRITE && hit_high;
  wire [7:0] wbyte = PWDATA[7:0];
  wire busy = (state != sadc_pkg::SADC_IDLE);
  wire eight_bit = mode[6];
  wire [2:0] time_code = {result_low[0], mode[1:0]};
  // Divider ratio 1/2^code: the whole conversion then takes 2^code thirds of base
  wire [7:0] base = eight_bit ? `SADC_BASE_8 : `SADC_BASE_12;
  wire [3:0] steps = eight_bit ? `SADC_BITS_8 : `SADC_BITS_12;
  wire [15:0] scaled = 16'({8'h00, base} << time_code);
  wire [15:0] normal_time = 16'((scaled + `SADC_FIXED_TERM) / `SADC_THIRDS);
  wire [15:0] plain_len = (normal_time == 16'h0000) ? 16'h0001 : normal_time;
  wire [15:0] total_len = long_pending && !eight_bit ? 16'(plain_len << 1) : plain_len;
  wire [15:0] per_step = 16'(total_len / {12'h000, steps});
  wire start_req = write_control && wbyte[2] && !busy;
  wire abort_req = write_control && !wbyte[2] && busy;
  wire [3:0] step_bit = 4'(steps - 4'h1 - bit_index);
  wire last_step = (state == sadc_pkg::SADC_STEP) && (step_count == 16'h0000) && (bit_index == 4'(steps - 4'h1));
  wire [11:0] trial = approx | (12'h001 << step_bit);
  wire [11:0] kept = COMPARATOR_HIGH ? trial : approx;
  wire [7:0] ctrl_write = (wbyte & `SADC_CTRL_WMASK);
  wire [7:0] read_mux = hit_control ? control :
                        hit_mode ? mode :
                        hit_low ? result_low :
                        hit_high ? result_high : `SADC_RESET_BYTE;

  assign PREADY = 1'b1;
  assign PSLVERR = bus_access && !hit_any;
  assign LADDER_ENABLE = busy;
  assign DONE_IRQ = control.done && control.irq_enable;
  assign TRIAL_CODE = trial;
  assign SAMPLE_STROBE = (state == sadc_pkg::SADC_STEP) && (step_count == 16'h0000);

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h000000, read_mux};
    end
  end

  // Codes above 13 are not expected; they are clamped to the last input
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      CHANNEL_SELECT <= 4'h0;
    end else if (start_req) begin
      CHANNEL_SELECT <= (wbyte[7:4] > `SADC_CHAN_LAST) ? `SADC_CHAN_LAST : wbyte[7:4];
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      control <= `SADC_RESET_BYTE;
    end else begin
      if (write_control) begin
        control <= ctrl_write;
      end
      if (last_step) begin
        control.run <= 1'b0;
        control.done <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      mode <= `SADC_RESET_BYTE;
    end else if (write_mode) begin
      mode <= wbyte & `SADC_MODE_WMASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      result_low <= `SADC_RESET_BYTE;
      result_high <= `SADC_RESET_BYTE;
    end else begin
      if (write_low) begin
        result_low <= (wbyte & `SADC_LOW_WMASK) | (result_low & 8'hF0);
      end
      if (write_high) begin
        result_high <= wbyte;
      end
      if (last_step && eight_bit) begin
        result_high <= kept[7:0];
      end else if (last_step) begin
        result_high <= kept[11:4];
        result_low[7:4] <= kept[3:0];
      end
    end
  end

  // Long first conversion after reset or an 8 to 12 switch
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      long_pending <= 1'b1;
    end else if (write_mode && eight_bit && !wbyte[6]) begin
      long_pending <= 1'b1;
    end else if (last_step && !eight_bit) begin
      long_pending <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      state <= sadc_pkg::SADC_IDLE;
      approx <= 12'h000;
      bit_index <= 4'h0;
      step_count <= 16'h0000;
    end else begin
      unique case (state)
        sadc_pkg::SADC_IDLE: begin
          if (start_req) begin
            state <= sadc_pkg::SADC_STEP;
            approx <= 12'h000;
            bit_index <= 4'h0;
            step_count <= (per_step == 16'h0000) ? 16'h0000 : 16'(per_step - 16'h0001);
          end
        end
        sadc_pkg::SADC_SETTLE: begin
          state <= sadc_pkg::SADC_STEP;
        end
        sadc_pkg::SADC_STEP: begin
          if (abort_req || last_step) begin
            state <= sadc_pkg::SADC_IDLE;
          end else if (step_count != 16'h0000) begin
            step_count <= 16'(step_count - 16'h0001);
          end else begin
            approx <= kept;
            bit_index <= 4'(bit_index + 4'h1);
            step_count <= (per_step == 16'h0000) ? 16'h0000 : 16'(per_step - 16'h0001);
          end
        end
      endcase
    end
  end

  // Fine counter spans the whole conversion for checking its length
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      fine_count <= 16'h0000;
    end else if (!busy) begin
      fine_count <= 16'h0000;
    end else begin
      fine_count <= 16'(fine_count + 16'h0001);
    end
  end

  a_irq_level: assert property (@(posedge MCLK) disable iff (!RESETN)
    DONE_IRQ == (control.done && control.irq_enable)) else $error("irq level wrong");
  a_run_clears: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step |=> !control.run && control.done) else $error("run not cleared at end");
  a_done_sticky: assert property (@(posedge MCLK) disable iff (!RESETN)
    control.done && !write_control |=> control.done) else $error("done cleared by hardware");
  a_done_set: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step |=> control.done) else $error("done not set");
  a_ladder_busy: assert property (@(posedge MCLK) disable iff (!RESETN)
    start_req |=> LADDER_ENABLE) else $error("ladder not on");
  a_abort_idle: assert property (@(posedge MCLK) disable iff (!RESETN)
    abort_req |=> !busy) else $error("abort ignored");
  a_low_kept8: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step && eight_bit && !write_low |=> $stable(result_low)) else $error("low changed in 8-bit");
  a_high12: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step && !eight_bit |=> result_high == $past(kept[11:4])) else $error("high result wrong");
  a_channel_range: assert property (@(posedge MCLK) disable iff (!RESETN)
    CHANNEL_SELECT <= `SADC_CHAN_LAST) else $error("channel out of range");
  a_reset_halts: assert property (@(posedge MCLK)
    !RESETN |=> !busy && !control.run) else $error("reset did not halt");
  a_length_bound: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step |-> fine_count < total_len + 16'h0010) else $error("conversion too long");

  // Steps of a conversion, shared by the checks below
  sequence s_start_taken;
    start_req && !busy;
  endsequence

  sequence s_converting;
    busy && LADDER_ENABLE;
  endsequence

  sequence s_end_step;
    last_step;
  endsequence

  sequence s_idle_done;
    !busy && !LADDER_ENABLE && control.done && !control.run;
  endsequence

  a_start_busy: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_start_taken |=> s_converting) else $error("start not taken");

  a_end_idle: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_end_step |=> s_idle_done) else $error("end did not return to idle");

  a_start_run: assert property (@(posedge MCLK) disable iff (!RESETN)
    start_req |=> control.run) else $error("run bit not set");

  a_abort_run: assert property (@(posedge MCLK) disable iff (!RESETN)
    abort_req |=> !control.run && !LADDER_ENABLE) else $error("abort left run set");

  a_chan_latch: assert property (@(posedge MCLK) disable iff (!RESETN)
    start_req && (wbyte[7:4] <= `SADC_CHAN_LAST) |=> CHANNEL_SELECT == $past(wbyte[7:4])) else $error("channel not latched");

  a_chan_steady: assert property (@(posedge MCLK) disable iff (!RESETN)
    busy |=> $stable(CHANNEL_SELECT)) else $error("channel moved mid conversion");

  a_low12: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step && !eight_bit |=> result_low[7:4] == $past(kept[3:0])) else $error("low result wrong");

  a_high8: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step && eight_bit |=> result_high == $past(kept[7:0])) else $error("8-bit result wrong");

  a_long_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step && !eight_bit |=> !long_pending) else $error("long flag not cleared");

  a_long_arm: assert property (@(posedge MCLK) disable iff (!RESETN)
    write_mode && eight_bit && !wbyte[6] |=> long_pending) else $error("long flag not armed");

  a_strobe_busy: assert property (@(posedge MCLK) disable iff (!RESETN)
    SAMPLE_STROBE |-> busy) else $error("strobe while idle");

  a_index_range: assert property (@(posedge MCLK) disable iff (!RESETN)
    busy |-> bit_index < steps) else $error("step index out of range");

  a_trial_bit: assert property (@(posedge MCLK) disable iff (!RESETN)
    SAMPLE_STROBE |-> TRIAL_CODE[step_bit]) else $error("trial bit not raised");

  // Remainder of the even split is dropped, so the run is short by fewer cycles than there are steps
  a_length_floor: assert property (@(posedge MCLK) disable iff (!RESETN)
    last_step |-> fine_count + 16'h0001 + {12'h000, steps} > total_len) else $error("conversion too short");

  a_done_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
    write_control && !wbyte[1] && !last_step |=> !control.done) else $error("done not cleared");

  a_irq_off: assert property (@(posedge MCLK) disable iff (!RESETN)
    !control.irq_enable |-> !DONE_IRQ) else $error("irq while disabled");

  a_slverr_map: assert property (@(posedge MCLK) disable iff (!RESETN)
    bus_access && hit_any |-> !PSLVERR) else $error("error on mapped access");
endmodule : sadc_sequencer

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] A_CTL = 32'h0003F960;
  localparam logic [31:0] A_MODE = 32'h0003F964;
  localparam logic [31:0] A_LOW = 32'h0003F968;
  localparam logic [31:0] A_HIGH = 32'h0003F96C;
  localparam logic [31:0] A_BAD = 32'h00000010;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, LADDER_ENABLE, SAMPLE_STROBE, DONE_IRQ;
  logic [3:0] CHANNEL_SELECT;
  logic [11:0] TRIAL_CODE;
  logic [11:0] target = 12'h5A3;
  logic [7:0] rd;
  logic err;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int busy_len = 0;
  int l1;
  int l2;
  // Analog stand-in: must follow the trial word in the same cycle, so it is combinational
  wire COMPARATOR_HIGH = (target >= TRIAL_CODE);
  sadc_sequencer i_dut (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .COMPARATOR_HIGH(COMPARATOR_HIGH), .CHANNEL_SELECT(CHANNEL_SELECT), .TRIAL_CODE(TRIAL_CODE),
    .LADDER_ENABLE(LADDER_ENABLE), .SAMPLE_STROBE(SAMPLE_STROBE), .DONE_IRQ(DONE_IRQ));
  initial begin
    forever #20 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cycles++;
    if (LADDER_ENABLE === 1'b1) busy_len++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA[7:0];
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rdchk(input logic [31:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk({4'h0, rd}, {4'h0, exp});
  endtask : rdchk
  task tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick
  task wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, A_CTL, 8'h00);
      i++;
    end while (rd[2] !== 1'b0 && i < 600);
    tick(1);
  endtask : wait_idle
  task t_regs;
    rdchk(A_CTL, 8'h00);
    rdchk(A_MODE, 8'h00);
    rdchk(A_LOW, 8'h00);
    rdchk(A_HIGH, 8'h00);
    apb(1'b1, A_BAD, 8'hFF);
    chk({11'h0, err}, 12'h001);
    rdchk(A_BAD, 8'h00);
    rdchk(A_CTL, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task t_conv12;
    apb(1'b1, A_LOW, 8'h01);
    apb(1'b1, A_CTL, 8'h55);
    tick(2);
    chk({11'h0, LADDER_ENABLE}, 12'h001);
    chk({8'h0, CHANNEL_SELECT}, 12'h005);
    wait_idle();
    l1 = busy_len;
    chk({11'h0, l1 >= 545 && l1 <= 556}, 12'h001);
    rdchk(A_CTL, 8'h53);
    chk({11'h0, DONE_IRQ}, 12'h001);
    chk({11'h0, LADDER_ENABLE}, 12'h000);
    rdchk(A_HIGH, 8'h5A);
    rdchk(A_LOW, 8'h31);
    apb(1'b1, A_CTL, 8'h55);
    wait_idle();
    chk({11'h0, l1 > (busy_len - l1) * 3 / 2}, 12'h001);
    chk({11'h0, (busy_len - l1) >= 267 && (busy_len - l1) <= 278}, 12'h001);
    apb(1'b1, A_CTL, 8'h51);
    tick(1);
    chk({11'h0, DONE_IRQ}, 12'h000);
    $display("test conv12 done");
  endtask : t_conv12
  task t_conv8;
    target = 12'h0AA;
    l2 = busy_len;
    apb(1'b1, A_MODE, 8'h40);
    apb(1'b1, A_CTL, 8'hD4);
    tick(2);
    chk({8'h0, CHANNEL_SELECT}, 12'h00D);
    wait_idle();
    chk({11'h0, (busy_len - l2) >= 164 && (busy_len - l2) <= 171}, 12'h001);
    rdchk(A_CTL, 8'hD2);
    chk({11'h0, DONE_IRQ}, 12'h000);
    rdchk(A_HIGH, 8'hAA);
    rdchk(A_LOW, 8'h31);
    $display("test conv8 done");
  endtask : t_conv8
  task t_abort;
    apb(1'b1, A_MODE, 8'h00);
    apb(1'b1, A_CTL, 8'h04);
    tick(3);
    apb(1'b1, A_CTL, 8'h00);
    tick(1);
    chk({11'h0, LADDER_ENABLE}, 12'h000);
    rdchk(A_CTL, 8'h00);
    $display("test abort done");
  endtask : t_abort
  task t_reset_mid;
    apb(1'b1, A_CTL, 8'h04);
    tick(5);
    RESETN <= 1'b0;
    tick(2);
    RESETN <= 1'b1;
    tick(1);
    chk({11'h0, LADDER_ENABLE}, 12'h000);
    rdchk(A_CTL, 8'h00);
    $display("test reset_mid done");
  endtask : t_reset_mid
  initial begin
    tick(6);
    RESETN <= 1'b1;
    t_regs();
    t_conv12();
    t_conv8();
    t_abort();
    t_reset_mid();
    summarize();
  end
endmodule : tb
